// ===== sim/dscp_host_model.sv
// spi host and i2c controller model on the far side of the port
`timescale 1ns/1ps
module dscp_host_model (
   input  wire logic clk,
   output logic      sel_n,
   output logic      sck,
   output logic      serial_input_line,
   input  wire logic serial_output_line,
   input  wire logic sdo_oe,
   output logic      scl,
   output wire logic sda,
   input  wire logic sda_o,
   input  wire logic sda_oe
);
   int          q = 50;  // quarter i2c bit time in clk cycles
   logic [47:0] rx;      // bits seen on the serial output line
   logic        pull_q;  // controller holds sda low

   // open-drain sda with pull-up: low if either side pulls
   assign sda = !(pull_q || (sda_oe && !sda_o));

   // idle levels: deselected, clocks standing still, sda released
   initial begin
      sel_n  = 1'b1;
      sck    = 1'b0;
      serial_input_line    = 1'b0;
      scl    = 1'b1;
      pull_q = 1'b0;
      rx     = '0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one frame of n bits, msb first; output sampled at the launch edge, before it moves
   task automatic spi_frame(input int n, input logic [47:0] bits, input logic rise);
      sel_n <= 1'b0;
      tick(4);
      for (int i = n - 1; i >= 0; i--) begin
         tick(4);
         serial_input_line <= bits[i]; // data moves well away from the falling edge
         tick(4);
         if (rise) rx <= {rx[46:0], sdo_oe ? serial_output_line : 1'bz};
         sck <= 1'b1;
         tick(8);
         if (!rise) rx <= {rx[46:0], sdo_oe ? serial_output_line : 1'bz};
         sck <= 1'b0;
      end
      tick(8);
      sel_n <= 1'b1;
      serial_input_line <= ~serial_input_line; // released line no longer shows the last bit
      tick(8);
   endtask

   // start or repeated start: sda falls while scl high
   task automatic i2c_start();
      pull_q <= 1'b0;
      tick(q);
      scl <= 1'b1;
      tick(q);
      pull_q <= 1'b1;
      tick(q);
      scl <= 1'b0;
      tick(q);
   endtask

   // stop: sda rises while scl high
   task automatic i2c_stop();
      pull_q <= 1'b1;
      tick(q);
      scl <= 1'b1;
      tick(q);
      pull_q <= 1'b0;
      tick(q);
   endtask

   // one bit: sda set during scl low, sampled mid high phase
   task automatic i2c_bit(input logic b, output logic r);
      pull_q <= !b;
      tick(q);
      scl <= 1'b1;
      tick(q);
      r = sda;
      tick(q);
      scl <= 1'b0;
      tick(q);
   endtask

   // eight bits then the ninth clock; a read passes 8'hff and its own ack level
   task automatic i2c_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                           output logic ack);
      for (int i = 7; i >= 0; i--) i2c_bit(d[i], r[i]);
      i2c_bit(ack_in, ack);
   endtask
endmodule

// ===== sim/dscp_port_monitor.sv
// pin-level assertions for the configuration port
`timescale 1ns/1ps
module dscp_port_monitor (
   input wire logic       CLK,
   input wire logic       RESETN,
   input wire logic       FRAME_SEL_N,
   input wire logic       READOUT_PIN_ENABLE,
   input wire logic       SERIAL_OUTPUT_LINE_OE,
   input wire logic       SCL_I,
   input wire logic       SDA_O,
   input wire logic       SDA_OE,
   input wire logic [6:0] RD_ADDR,
   input wire logic       WR_STB,
   input wire logic       SOFT_RESET
);
   // single domain, so clock and reset are given once
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   // spi output enable; repeat counts leave room for the pin synchroniser delay
   a_oe_idle_off: assert property (FRAME_SEL_N [*6] |-> !SERIAL_OUTPUT_LINE_OE)
      else $error("serial output driven outside a frame");
   a_oe_three_wire: assert property (!READOUT_PIN_ENABLE [*3] |-> !SERIAL_OUTPUT_LINE_OE)
      else $error("serial output driven in three-wire mode");
   a_oe_in_frame: assert property ((READOUT_PIN_ENABLE && !FRAME_SEL_N) [*6]
      |-> SERIAL_OUTPUT_LINE_OE)
      else $error("serial output not driven in four-wire frame");

   // spi results appear only once the frame has closed
   a_wr_frame_done: assert property (WR_STB |-> FRAME_SEL_N)
      else $error("write strobe inside a frame");
   a_wr_one_cycle: assert property (WR_STB |=> !WR_STB)
      else $error("write strobe longer than one cycle");
   a_rd_addr_idle: assert property ($changed(RD_ADDR) |-> FRAME_SEL_N)
      else $error("read address changed inside a frame");

   // i2c data line only moves while the clock is low
   a_ack_scl_low: assert property ($rose(SDA_OE) |-> !SCL_I)
      else $error("sda pulled while scl high");
   a_sda_hold_high: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE))
      else $error("sda changed during scl high");
   a_sda_open_drain: assert property (SDA_OE |-> !SDA_O)
      else $error("sda driven high");

   // general call reset lands inside the acknowledge high phase
   a_reset_in_ack: assert property (SOFT_RESET |-> SCL_I && SDA_OE)
      else $error("soft reset outside ack high phase");
   a_reset_one_cycle: assert property (SOFT_RESET |=> !SOFT_RESET)
      else $error("soft reset longer than one cycle");

   // main scenarios reached
   c_write: cover property (WR_STB);
   c_reset: cover property (SOFT_RESET);
   c_readout: cover property (SERIAL_OUTPUT_LINE_OE && !FRAME_SEL_N);
endmodule

bind dscp_port dscp_port_monitor u_mon (
   .CLK(CLK), .RESETN(RESETN), .FRAME_SEL_N(FRAME_SEL_N),
   .READOUT_PIN_ENABLE(READOUT_PIN_ENABLE), .SERIAL_OUTPUT_LINE_OE(SERIAL_OUTPUT_LINE_OE),
   .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .RD_ADDR(RD_ADDR), .WR_STB(WR_STB),
   .SOFT_RESET(SOFT_RESET)
);

// ===== sim/dscp_port_tb.sv
// self-checking testbench for the configuration port
`timescale 1ns/1ps
module dscp_port_tb;
   logic        clk      = 1'b0;
   logic        rst_n    = 1'b0;
   logic        rpe      = 1'b0;  // readout pin enable
   logic        res      = 1'b0;  // readout edge select
   logic [2:0]  strap    = 3'h0;
   logic [15:0] rdata    = 16'h0;
   logic        sel_n, sck, serial_input_line, serial_output_line, sdo_oe, scl, sda, sda_o, sda_oe;
   logic        wr_stb, soft_rst;
   logic [6:0]  rd_addr, wr_addr, wr_a;
   logic [15:0] wr_data, wr_d;
   logic [15:0] mem [128];
   int          wr_n = 0, sr_n = 0, num_errors = 0, num_checks = 0;

   always #2.5 clk = ~clk;

   dscp_port DUT (
      .CLK(clk), .RESETN(rst_n), .FRAME_SEL_N(sel_n), .SHIFT_CLK(sck),
      .SERIAL_INPUT_LINE(serial_input_line), .SERIAL_OUTPUT_LINE_O(serial_output_line), .SERIAL_OUTPUT_LINE_OE(sdo_oe),
      .READOUT_PIN_ENABLE(rpe), .READOUT_EDGE_SELECT(res), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDRESS_SELECT_PIN(strap),
      .READBACK_DATA_FIELD(rdata), .RD_ADDR(rd_addr), .WR_STB(wr_stb), .WR_ADDR(wr_addr),
      .WR_DATA(wr_data), .SOFT_RESET(soft_rst)
   );

   dscp_host_model u_host (
      .clk(clk), .sel_n(sel_n), .sck(sck), .serial_input_line(serial_input_line), .serial_output_line(serial_output_line), .sdo_oe(sdo_oe),
      .scl(scl), .sda(sda), .sda_o(sda_o), .sda_oe(sda_oe)
   );

   // register file stand-in: contents follow the read address; strobes are counted
   always @(posedge clk) begin
      rdata <= mem[rd_addr];
      if (wr_stb === 1'b1) begin
         wr_n <= wr_n + 1;
         wr_a <= wr_addr;
         wr_d <= wr_data;
      end
      if (soft_rst === 1'b1) sr_n <= sr_n + 1;
   end

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // target address byte: fixed upper nibble and the strapped bits
   function automatic logic [7:0] tgt(input logic rw);
      return {4'h9, strap, rw};
   endfunction

   // readback word: echoed read flag and address, then register contents
   function automatic logic [23:0] echo_exp(input logic [6:0] ra);
      return {1'b1, ra, mem[ra]};
   endfunction

   // one spi frame, then the number of writes it caused and their content
   task automatic spi_try(input int n, input logic [47:0] bits, input int cnt,
                          input logic [22:0] exp);
      int n0;
      @(posedge clk);
      n0 = wr_n;
      u_host.spi_frame(n, bits, res);
      check("spi write count", 24'(wr_n - n0), 24'(cnt));
      if (cnt > 0) check("spi write", {1'b0, wr_a, wr_d}, {1'b0, exp});
   endtask

   // one i2c byte written by the controller and the ack level expected back
   task automatic i2c_send(input logic [7:0] b, input logic k_exp);
      logic [7:0] r;
      logic       k;
      u_host.i2c_byte(b, 1'b1, r, k);
      check("i2c ack", 24'(k), 24'(k_exp));
   endtask

   // hang guard: counts as a mismatch
   initial begin
      #450000;
      num_errors++;
      end_of_test();
   end

   initial begin
      logic [6:0]  a;
      logic [15:0] d;
      logic [7:0]  hi, lo;
      logic        k;
      int          n0;
      static int         qs [3] = '{500, 125, 50};
      static logic [7:0] gc [2] = '{8'h06, 8'h04};
      void'($urandom(11));
      foreach (mem[i]) mem[i] = 16'($urandom);
      strap <= 3'($urandom);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      // three-wire: writes, too short, too long, refused read
      for (int i = 0; i < 3; i++) begin
         a = 7'($urandom);
         d = 16'($urandom);
         spi_try(24, 48'({1'b0, a, d}), 1, {a, d});
      end
      spi_try(23, 48'({a, d}), 0, '0);
      spi_try(30, 48'({1'b0, a, d, 6'h2a}), 1, {a, d});
      spi_try(24, 48'({1'b1, 7'h5a, d}), 0, '0);
      check("rd addr three-wire", 24'(rd_addr), 24'h0);
      // four-wire read for both launch edges, then daisy-chain lengths
      rpe <= 1'b1;
      for (int e = 0; e < 2; e++) begin
         res <= e[0];
         a = 7'($urandom);
         d = 16'($urandom);
         spi_try(24, 48'({1'b1, a, d}), 0, '0);
         check("rd addr spi", 24'(rd_addr), 24'(a));
         spi_try(24, 48'({1'b0, ~a, d}), 1, {~a, d});
         check("spi readback", u_host.rx[23:0], echo_exp(a));
      end
      spi_try(48, {24'($urandom), 1'b0, a, d}, 1, {a, d});
      spi_try(36, 48'({12'h3c5, 1'b0, a, d}), 0, '0);
      rpe <= 1'b0;
      // address probe at 100, 400 and 1000 kbit/s
      foreach (qs[i]) begin
         u_host.q = qs[i];
         u_host.i2c_start();
         i2c_send(tgt(1'b0), 1'b0);
         u_host.i2c_stop();
      end
      // i2c write, then a byte after stop with no start
      a = 7'($urandom);
      d = 16'($urandom);
      n0 = wr_n;
      u_host.i2c_start();
      i2c_send(tgt(1'b0), 1'b0);
      i2c_send({1'b0, a}, 1'b0);
      i2c_send(d[15:8], 1'b0);
      i2c_send(d[7:0], 1'b0);
      u_host.i2c_stop();
      check("i2c write count", 24'(wr_n - n0), 24'h1);
      check("i2c write", {1'b0, wr_a, wr_d}, {1'b0, a, d});
      i2c_send(tgt(1'b0), 1'b1);
      // foreign and 10-bit headers are left unanswered
      u_host.i2c_start();
      i2c_send({4'h9, ~strap, 1'b0}, 1'b1);
      i2c_send({1'b0, a}, 1'b1);
      u_host.i2c_start();
      i2c_send({5'h1e, 2'h0, 1'b0}, 1'b1);
      // i2c read with repeated start
      a = 7'($urandom);
      u_host.i2c_start();
      i2c_send(tgt(1'b0), 1'b0);
      i2c_send({1'b0, a}, 1'b0);
      u_host.i2c_start();
      i2c_send(tgt(1'b1), 1'b0);
      u_host.i2c_byte(8'hff, 1'b0, hi, k);
      u_host.i2c_byte(8'hff, 1'b1, lo, k);
      u_host.i2c_stop();
      check("i2c read", 24'({hi, lo}), 24'(mem[a]));
      check("rd addr i2c", 24'(rd_addr), 24'(a));
      // general call: only the reset code pulses, before the stop arrives
      foreach (gc[i]) begin
         n0 = sr_n;
         u_host.i2c_start();
         i2c_send(8'h00, 1'b0);
         i2c_send(gc[i], 1'b0);
         check("soft reset", 24'(sr_n - n0), 24'(gc[i] == 8'h06));
         u_host.i2c_stop();
      end
      end_of_test();
   end
endmodule

// ===== verilog/dscp_pkg.sv
// shared constants and state codes for the dual serial configuration port
package dscp_pkg;

   // spi frame layout
   localparam int          FRAME_BITS = 24;
   localparam int          DATA_BITS  = 16;
   localparam int          ADDR_BITS  = 7;
   localparam int          RW_POS     = 23;
   localparam int          ADDR_HI    = 22;
   localparam int          ADDR_LO    = 16;
   localparam logic [4:0]  CNT_LAST   = 5'h17;
   localparam logic [4:0]  CNT_ZERO   = 5'h00;

   // i2c addressing and general call
   localparam logic [3:0]  TGT_ADDR_HI = 4'h9;
   localparam logic [7:0]  GC_ADDR     = 8'h00;
   localparam logic [7:0]  GC_RESET    = 8'h06;
   localparam logic [3:0]  BYTE_DONE   = 4'h8;
   localparam logic [3:0]  BIT_ONE     = 4'h1;
   localparam logic [1:0]  IDX_CMD     = 2'h0;
   localparam logic [1:0]  IDX_UPPER   = 2'h1;
   localparam logic [1:0]  IDX_LOWER   = 2'h2;

   // highest i2c bit rate served, in kbit/s
   localparam int          I2C_MAX_KBPS = 1000;

   // i2c target states
   typedef enum logic [2:0] {
      I2C_IDLE  = 3'b000,
      I2C_ADDR  = 3'b001,
      I2C_ACK_A = 3'b010,
      I2C_WDATA = 3'b011,
      I2C_ACK_W = 3'b100,
      I2C_TX    = 3'b101,
      I2C_ACK_R = 3'b110
   } dscp_i2c_e;

endpackage

// ===== verilog/dscp_port.sv
// spi and i2c configuration and readback port, top module
// Contract
// - spi frame runs from frame select falling low until it returns high
// - serial input sampled on each shift clock falling edge within a frame
// - frames with fewer than 24 falling edges are discarded
// - three-wire mode is reset default; only first 24 bits are used
// - outside a frame shift clock and input ignored, output released
// - frame is instruction byte then 16 data bits
// - spi reads only served when readout pin enable is set
// - read takes a command frame then a second frame carrying data
// - readback frame echoes flag, address, then register contents
// - output bits launched on falling or rising edge per edge select
// - four-wire: multiples of 24 use last 24 bits, others dropped
// - i2c target with 7-bit addresses only, no 10-bit format
// - same byte protocol at 100, 400 and 1000 kbit/s
// - start, 0x00, 0x06, stop sequence triggers software reset
// - software reset fires on rising scl of ack after second byte
// - ninth clock acknowledge: sda low through its high phase
// - sda falling while scl high is a start condition
// - address byte acknowledged only on own address match; general call address 0x00 is acked too
// - receiver of each data byte acknowledges it
// - stop releases the bus; wait for new start and address
// - target address is 1001 plus three strapped bits
// - i2c write: address, command, upper byte, lower byte, all acked
// - i2c read: command write, repeated start, upper then lower byte
`timescale 1ns/1ps
module dscp_port (
   input  wire logic        CLK,
   input  wire logic        RESETN,
   input  wire logic        FRAME_SEL_N,
   input  wire logic        SHIFT_CLK,
   input  wire logic        SERIAL_INPUT_LINE,
   output logic             SERIAL_OUTPUT_LINE_O,
   output logic             SERIAL_OUTPUT_LINE_OE,
   input  wire logic        READOUT_PIN_ENABLE,
   input  wire logic        READOUT_EDGE_SELECT,
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE,
   input  wire logic [2:0]  ADDRESS_SELECT_PIN,
   input  wire logic [15:0] READBACK_DATA_FIELD,
   output logic [6:0]       RD_ADDR,
   output logic             WR_STB,
   output logic [6:0]       WR_ADDR,
   output logic [15:0]      WR_DATA,
   output logic             SOFT_RESET
);

   // synchronised pins: frame sel, shift clk, input, scl, sda, strap
   logic [7:0]  pins_s;
   logic        fsn_s, sck_s, sdi_s, scl_s, sda_s;
   logic [2:0]  asel_s;

   dscp_sync2 #(
      .W    (8),
      .INIT (8'h9b)  // idle pin levels, so no false edge follows reset
   ) u_sync (
      .CLK    (CLK),
      .RESETN (RESETN),
      .D      ({FRAME_SEL_N, SHIFT_CLK, SERIAL_INPUT_LINE, SCL_I, SDA_I,
                ADDRESS_SELECT_PIN}),
      .Q      (pins_s)
   );

   assign fsn_s  = pins_s[7];
   assign sck_s  = pins_s[6];
   assign sdi_s  = pins_s[5];
   assign scl_s  = pins_s[4];
   assign sda_s  = pins_s[3];
   assign asel_s = pins_s[2:0];

   // previous samples for edge finding
   logic fsn_p_q, sck_p_q, scl_p_q, sda_p_q;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         fsn_p_q <= 1'b1;
         sck_p_q <= 1'b0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         fsn_p_q <= fsn_s;
         sck_p_q <= sck_s;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // ---------------- spi side ----------------
   logic f_act, f_start, f_end, sck_fall, sck_rise, launch;

   assign f_act    = !fsn_s;
   assign f_start  = fsn_p_q && !fsn_s;
   assign f_end    = !fsn_p_q && fsn_s;
   // clock edges only count inside a frame
   assign sck_fall = f_act && sck_p_q && !sck_s;
   assign sck_rise = f_act && !sck_p_q && sck_s;
   assign launch   = READOUT_EDGE_SELECT ? sck_rise : sck_fall;

   logic [23:0] in_q, first_q;
   logic [4:0]  cnt_q;
   logic        full_q;

   // input shift and edge count, modulo one frame length
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         in_q    <= '0;
         first_q <= '0;
         cnt_q   <= dscp_pkg::CNT_ZERO;
         full_q  <= 1'b0;
      end else if (f_start) begin
         cnt_q  <= dscp_pkg::CNT_ZERO;
         full_q <= 1'b0;
      end else if (sck_fall) begin
         in_q <= {in_q[22:0], sdi_s};
         if (cnt_q == dscp_pkg::CNT_LAST) begin
            cnt_q  <= dscp_pkg::CNT_ZERO;
            full_q <= 1'b1;
            // keep the first whole word for three-wire use
            if (!full_q) begin
               first_q <= {in_q[22:0], sdi_s};
            end
         end else begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end

   // frame verdict at frame select release
   logic        four_wire, spi_ok, spi_rd, spi_wr, spi_rdcmd;
   logic [23:0] spi_word;

   assign four_wire = READOUT_PIN_ENABLE;
   // three-wire needs 24 edges; four-wire needs a whole multiple
   assign spi_ok    = four_wire ? (full_q && cnt_q == dscp_pkg::CNT_ZERO)
                                : full_q;
   assign spi_word  = four_wire ? in_q : first_q;
   assign spi_rd    = spi_word[dscp_pkg::RW_POS];
   assign spi_wr    = f_end && spi_ok && !spi_rd;
   // a read command in three-wire mode has no way back and is dropped
   assign spi_rdcmd = f_end && spi_ok && spi_rd && four_wire;

   // echo of the last accepted instruction byte
   logic [7:0]  echo_q;
   logic [23:0] out_q;
   logic        sdo_oe_q;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         echo_q <= '0;
      end else if (f_end && spi_ok) begin
         echo_q <= spi_word[dscp_pkg::RW_POS:dscp_pkg::ADDR_LO];
      end
   end

   // output shifter; daisy chain passes received bits on after the word
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         out_q <= '0;
      end else if (f_start) begin
         out_q <= {echo_q, READBACK_DATA_FIELD};
      end else if (launch) begin
         out_q <= {out_q[22:0], READOUT_EDGE_SELECT ? in_q[0] : sdi_s};
      end
   end

   // output only driven inside a frame and in four-wire mode
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sdo_oe_q <= 1'b0;
      end else begin
         sdo_oe_q <= f_act && four_wire;
      end
   end

   assign SERIAL_OUTPUT_LINE_O  = out_q[dscp_pkg::RW_POS];
   assign SERIAL_OUTPUT_LINE_OE = sdo_oe_q;

   // ---------------- i2c side ----------------
   logic scl_rise, scl_fall, i2c_start, i2c_stop;

   assign scl_rise  = !scl_p_q && scl_s;
   assign scl_fall  = scl_p_q && !scl_s;
   // sda moving under a high scl marks start or stop
   assign i2c_start = scl_p_q && scl_s && sda_p_q && !sda_s;
   assign i2c_stop  = scl_p_q && scl_s && !sda_p_q && sda_s;

   dscp_pkg::dscp_i2c_e st_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q, upper_q;
   logic [1:0]  idx_q;
   logic [6:0]  cmd_q;
   logic [15:0] tx_q;
   logic [2:0]  asel_q;
   logic        rd_q, gc_q, lower_q, sda_oe_q, addr_hit, gc_hit;

   // fixed upper nibble, strapped lower bits; 10-bit headers never match
   assign addr_hit = sh_q[7:1] == {dscp_pkg::TGT_ADDR_HI, asel_q};
   assign gc_hit   = sh_q == dscp_pkg::GC_ADDR;

   // byte-level target sequencer, same at every bit rate
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_q     <= dscp_pkg::I2C_IDLE;
         bit_q    <= '0;
         sh_q     <= '0;
         idx_q    <= dscp_pkg::IDX_CMD;
         cmd_q    <= '0;
         upper_q  <= '0;
         tx_q     <= '0;
         asel_q   <= '0;
         rd_q     <= 1'b0;
         gc_q     <= 1'b0;
         lower_q  <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (i2c_start) begin
         st_q     <= dscp_pkg::I2C_ADDR;
         bit_q    <= '0;
         gc_q     <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (i2c_stop) begin
         st_q     <= dscp_pkg::I2C_IDLE;
         sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
         case (st_q)
            dscp_pkg::I2C_ADDR, dscp_pkg::I2C_WDATA: begin
               // data is stable while scl is high, so sample here
               sh_q  <= {sh_q[6:0], sda_s};
               bit_q <= bit_q + 4'h1;
               if (st_q == dscp_pkg::I2C_ADDR && bit_q == 4'h0) begin
                  asel_q <= asel_s;
               end
            end
            dscp_pkg::I2C_ACK_R: begin
               // controller nack ends the read
               lower_q <= lower_q | sda_s;
               if (sda_s) begin
                  st_q <= dscp_pkg::I2C_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (st_q)
            dscp_pkg::I2C_ADDR: begin
               if (bit_q == dscp_pkg::BYTE_DONE) begin
                  if (addr_hit) begin
                     st_q     <= dscp_pkg::I2C_ACK_A;
                     rd_q     <= sh_q[0];
                     sda_oe_q <= 1'b1;
                  end else if (gc_hit) begin
                     st_q     <= dscp_pkg::I2C_ACK_A;
                     rd_q     <= 1'b0;
                     gc_q     <= 1'b1;
                     sda_oe_q <= 1'b1;
                  end else begin
                     st_q <= dscp_pkg::I2C_IDLE;
                  end
               end
            end
            dscp_pkg::I2C_ACK_A: begin
               idx_q <= dscp_pkg::IDX_CMD;
               if (rd_q) begin
                  // upper byte first, first bit driven right away
                  st_q     <= dscp_pkg::I2C_TX;
                  tx_q     <= READBACK_DATA_FIELD;
                  sda_oe_q <= !READBACK_DATA_FIELD[15];
                  bit_q    <= dscp_pkg::BIT_ONE;
                  lower_q  <= 1'b0;
               end else begin
                  st_q     <= dscp_pkg::I2C_WDATA;
                  sda_oe_q <= 1'b0;
                  bit_q    <= '0;
               end
            end
            dscp_pkg::I2C_WDATA: begin
               if (bit_q == dscp_pkg::BYTE_DONE) begin
                  st_q     <= dscp_pkg::I2C_ACK_W;
                  sda_oe_q <= 1'b1;
               end
            end
            dscp_pkg::I2C_ACK_W: begin
               sda_oe_q <= 1'b0;
               bit_q    <= '0;
               if (idx_q == dscp_pkg::IDX_CMD) begin
                  cmd_q <= sh_q[6:0];
               end
               if (idx_q == dscp_pkg::IDX_UPPER) begin
                  upper_q <= sh_q;
               end
               // further byte pairs rewrite the same register
               idx_q <= (idx_q == dscp_pkg::IDX_LOWER) ? dscp_pkg::IDX_UPPER
                                                       : idx_q + 2'h1;
               // after a general call byte only a stop or start matters
               st_q  <= gc_q ? dscp_pkg::I2C_IDLE : dscp_pkg::I2C_WDATA;
            end
            dscp_pkg::I2C_TX: begin
               tx_q <= {tx_q[14:0], 1'b0};
               if (bit_q == dscp_pkg::BYTE_DONE) begin
                  sda_oe_q <= 1'b0;
                  st_q     <= dscp_pkg::I2C_ACK_R;
               end else begin
                  sda_oe_q <= !tx_q[14];
                  bit_q    <= bit_q + 4'h1;
               end
            end
            dscp_pkg::I2C_ACK_R: begin
               // acked upper byte: lower byte follows, then wait
               if (!lower_q) begin
                  st_q     <= dscp_pkg::I2C_TX;
                  sda_oe_q <= !tx_q[15];
                  bit_q    <= dscp_pkg::BIT_ONE;
                  lower_q  <= 1'b1;
               end else begin
                  st_q <= dscp_pkg::I2C_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign SDA_O  = 1'b0;
   assign SDA_OE = sda_oe_q;

   // i2c events seen by the user side
   logic i2c_wr, i2c_cmd, i2c_gc_rst;

   assign i2c_wr     = scl_fall && st_q == dscp_pkg::I2C_ACK_W && !gc_q
                       && idx_q == dscp_pkg::IDX_LOWER;
   assign i2c_cmd    = scl_fall && st_q == dscp_pkg::I2C_ACK_W && !gc_q
                       && idx_q == dscp_pkg::IDX_CMD;
   // reset fires on the ack clock rise, before the closing stop
   assign i2c_gc_rst = scl_rise && st_q == dscp_pkg::I2C_ACK_W && gc_q
                       && sh_q == dscp_pkg::GC_RESET;

   // user-side register access outputs, all registered
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         WR_STB     <= 1'b0;
         WR_ADDR    <= '0;
         WR_DATA    <= '0;
         RD_ADDR    <= '0;
         SOFT_RESET <= 1'b0;
      end else begin
         WR_STB     <= spi_wr || i2c_wr;
         SOFT_RESET <= i2c_gc_rst;
         if (spi_wr) begin
            WR_ADDR <= spi_word[dscp_pkg::ADDR_HI:dscp_pkg::ADDR_LO];
            WR_DATA <= spi_word[dscp_pkg::DATA_BITS-1:0];
         end else if (i2c_wr) begin
            WR_ADDR <= cmd_q;
            WR_DATA <= {upper_q, sh_q};
         end
         // presented address lets the register file prepare readback
         if (spi_rdcmd) begin
            RD_ADDR <= spi_word[dscp_pkg::ADDR_HI:dscp_pkg::ADDR_LO];
         end else if (i2c_cmd) begin
            RD_ADDR <= sh_q[6:0];
         end
      end
   end

endmodule

// ===== verilog/dscp_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dscp_sync2 #(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         CLK,
   input  wire logic         RESETN,
   input  wire logic [W-1:0] D,
   output logic [W-1:0]      Q
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         meta_q <= INIT;
         Q      <= INIT;
      end else begin
         meta_q <= D;
         Q      <= meta_q;
      end
   end

endmodule
